// ===== verilog/cdt_pkg.sv
// Purpose: constants shared by the cascaded down timer files
// Assumes: byte-wide register port, one 100 MHz clock
// Notes:   control and interrupt offsets sit in unused reserved slots
package cdt_pkg;
   localparam logic [7:0] ADDR_LOW_RELOAD   = 8'h00_c8;
   localparam logic [7:0] ADDR_HIGH_RELOAD  = 8'h00_c9;
   localparam logic [7:0] ADDR_LOW_COUNT    = 8'h00_ca;
   localparam logic [7:0] ADDR_HIGH_COUNT   = 8'h00_cb;
   localparam logic [7:0] ADDR_CTRL_LOW     = 8'h00_cc;
   localparam logic [7:0] ADDR_IRQ_STATUS   = 8'h00_cd;
   localparam logic [7:0] ADDR_IRQ_MASK     = 8'h00_ce;
   localparam int         CTRL_ENABLE_BIT   = 0;
   localparam int         CTRL_RELOAD_BIT   = 1;
   localparam int         IRQ_ZERO_BIT      = 0;
   localparam logic [7:0] CTRL_RESET        = 8'h00_00;
   localparam logic [7:0] BYTE_RESET        = 8'h00_00;
   localparam logic [7:0] IRQ_MASK_RESET    = 8'h00_00;
   localparam logic [7:0] BYTE_ZERO         = 8'h00_00;
   localparam logic [7:0] BYTE_ONE          = 8'h00_01;
endpackage : cdt_pkg

// ===== verilog/cdt_byte_if.sv
// Purpose: carries one timer byte's write and writeback signals
// Assumes: single clock domain
// Notes:   reg side holds the byte, ctl side steers it
`timescale 1ns/1ps
interface cdt_byte_if;
   logic       sw_we;
   logic [7:0] sw_data;
   logic       hw_we;
   logic [7:0] hw_data;
   logic [7:0] value;
   modport reg_side (input sw_we, input sw_data, input hw_we,
                     input hw_data, output value);
   modport ctl_side (output sw_we, output sw_data, output hw_we,
                     output hw_data, input value);
endinterface : cdt_byte_if

// ===== verilog/cdt_byte_reg.sv
// Purpose: one timer count byte, software write over hardware writeback
// Assumes: at most one software and one hardware write per cycle
// Notes:   used for both count bytes
`timescale 1ns/1ps
module cdt_byte_reg (
   input  wire logic clk,
   input  wire logic rst,
   cdt_byte_if.reg_side bif
);
   logic [7:0] value_r;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         value_r <= cdt_pkg::BYTE_RESET;
      end else if (bif.sw_we) begin // R10
         value_r <= bif.sw_data; // R8
      end else if (bif.hw_we) begin
         value_r <= bif.hw_data;
      end
   end
   assign bif.value = value_r;
endmodule // cdt_byte_reg

// ===== verilog/cdt_timer.sv
// Purpose: 16-bit down timer built from two cascaded byte timers
// Assumes: register strobes are one cycle, never both at once
// Notes:   zero seen while running counts as the terminal event
`timescale 1ns/1ps
// Behaviour
// (R1) The two byte timers only ever run joined as one 16-bit timer.
// (R2) The high byte timer holds the upper byte, the low one the lower.
// (R3) Each byte timer has a writable and readable reload and count byte.
// (R4) Enabling starts counting down from the count already held.
// (R5) Counting goes on to zero, where an interrupt request is raised.
// (R6) Without auto-reload the timer stops at zero and clears its enable.
// (R7) With auto-reload the reload bytes are copied in and counting goes on.
// (R8) A count written while running is where counting continues from.
// (R9) A reload written while active is used at the next zero.
// (R10) A software write beats a same-cycle hardware writeback.
// (R11) Writes to any timer register are accepted at any time.
// (R12) Software uses the timer bytes for timing only.
// (R13) The low control register is all zeros after reset.
// (R14) The low control register holds enable and auto-reload bits.
// (R15) The count decrements as one 16-bit value, zero seen on all bits.
module cdt_timer (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic      [7:0] rdata,
   output logic            irq
);
   logic [7:0] low_reload_r;
   logic [7:0] high_reload_r;
   logic [7:0] ctrl_r;
   logic [7:0] irq_status_r;
   logic [7:0] irq_mask_r;
   logic [7:0] rdata_r;
   logic       irq_r;
   logic       running;
   logic       at_zero;
   logic       zero_evt;
   logic       auto_reload;
   logic       wr_low_cnt;
   logic       wr_high_cnt;
   logic       wr_ctrl;
   logic [15:0] count_now;
   logic [15:0] count_nxt;

   cdt_byte_if low_bif ();
   cdt_byte_if high_bif ();

   cdt_byte_reg u_low_count (
      .clk (clk),
      .rst (rst),
      .bif (low_bif)
   );
   cdt_byte_reg u_high_count (
      .clk (clk),
      .rst (rst),
      .bif (high_bif)
   );

   assign wr_low_cnt  = wr && (addr == cdt_pkg::ADDR_LOW_COUNT);
   assign wr_high_cnt = wr && (addr == cdt_pkg::ADDR_HIGH_COUNT);
   assign wr_ctrl     = wr && (addr == cdt_pkg::ADDR_CTRL_LOW);

   assign running     = ctrl_r[cdt_pkg::CTRL_ENABLE_BIT];
   assign auto_reload = ctrl_r[cdt_pkg::CTRL_RELOAD_BIT];
   assign count_now   = {high_bif.value, low_bif.value}; // R2 R1
   assign at_zero     = (count_now == 16'h0000); // R15
   assign zero_evt    = running && at_zero; // R5

   // single 16-bit step; borrow out of the low byte moves the high one
   always_comb begin
      if (zero_evt && auto_reload) begin
         count_nxt = {high_reload_r, low_reload_r}; // R7 R9
      end else begin
         count_nxt = count_now - 16'h0001; // R15 R4
      end
   end

   assign low_bif.sw_we    = wr_low_cnt; // R11
   assign low_bif.sw_data  = wdata;
   assign high_bif.sw_we   = wr_high_cnt; // R11
   assign high_bif.sw_data = wdata;
   // no writeback when stopping single-shot: the count rests at zero
   assign low_bif.hw_we    = running && !(at_zero && !auto_reload);
   assign low_bif.hw_data  = count_nxt[7:0];
   assign high_bif.hw_we   = running && !(at_zero && !auto_reload);
   assign high_bif.hw_data = count_nxt[15:8];

   // reload bytes
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         low_reload_r  <= cdt_pkg::BYTE_RESET;
         high_reload_r <= cdt_pkg::BYTE_RESET;
      end else if (wr) begin
         if (addr == cdt_pkg::ADDR_LOW_RELOAD) begin
            low_reload_r <= wdata; // R3 R9
         end
         if (addr == cdt_pkg::ADDR_HIGH_RELOAD) begin
            high_reload_r <= wdata; // R3 R9
         end
      end
   end

   // control; a software write beats the single-shot clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_r <= cdt_pkg::CTRL_RESET; // R13
      end else if (wr_ctrl) begin
         ctrl_r <= wdata; // R14 R10
      end else if (zero_evt && !auto_reload) begin
         ctrl_r[cdt_pkg::CTRL_ENABLE_BIT] <= 1'b0; // R6
      end
   end

   // sticky status, set beats write-one-to-clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_status_r <= cdt_pkg::BYTE_RESET;
      end else begin
         if (wr && (addr == cdt_pkg::ADDR_IRQ_STATUS)) begin
            irq_status_r <= irq_status_r & ~wdata;
         end
         if (zero_evt) begin
            irq_status_r[cdt_pkg::IRQ_ZERO_BIT] <= 1'b1; // R5
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_mask_r <= cdt_pkg::IRQ_MASK_RESET;
      end else if (wr && (addr == cdt_pkg::ADDR_IRQ_MASK)) begin
         irq_mask_r <= wdata & cdt_pkg::BYTE_ONE;
      end
   end

   // irq lags status by one cycle so it comes from a flop
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(irq_status_r & irq_mask_r);
      end
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_r <= cdt_pkg::BYTE_ZERO;
      end else if (rd) begin
         case (addr)
            cdt_pkg::ADDR_LOW_RELOAD:  rdata_r <= low_reload_r; // R3
            cdt_pkg::ADDR_HIGH_RELOAD: rdata_r <= high_reload_r;
            cdt_pkg::ADDR_LOW_COUNT:   rdata_r <= low_bif.value;
            cdt_pkg::ADDR_HIGH_COUNT:  rdata_r <= high_bif.value;
            cdt_pkg::ADDR_CTRL_LOW:    rdata_r <= ctrl_r;
            cdt_pkg::ADDR_IRQ_STATUS:  rdata_r <= irq_status_r;
            cdt_pkg::ADDR_IRQ_MASK:    rdata_r <= irq_mask_r;
            default:                   rdata_r <= cdt_pkg::BYTE_ZERO;
         endcase
      end else begin
         rdata_r <= cdt_pkg::BYTE_ZERO;
      end
   end

   assign rdata = rdata_r;
   assign irq   = irq_r;

   chk_single_shot_stop: assert property (@(posedge clk) disable iff (rst)
      (zero_evt && !auto_reload && !wr) |=> !running) // R6
      else $error("single shot did not clear enable");

   chk_reload_copy: assert property (@(posedge clk) disable iff (rst)
      (zero_evt && auto_reload && !wr) |=>
      (count_now == $past({high_reload_r, low_reload_r}))) // R7
      else $error("reload value not copied at zero");

   chk_decrement_step: assert property (@(posedge clk) disable iff (rst)
      (running && !at_zero && !wr) |=>
      (count_now == $past(count_now) - 16'h0001)) // R15
      else $error("count did not step down by one");

   chk_sw_wins: assert property (@(posedge clk) disable iff (rst)
      (wr_low_cnt && running) |=> (low_bif.value == $past(wdata))) // R10
      else $error("software count write lost");

   chk_irq_on_zero: assert property (@(posedge clk) disable iff (rst)
      (zero_evt && irq_mask_r[cdt_pkg::IRQ_ZERO_BIT] && !wr) |-> ##2 irq)
      // R5
      else $error("no interrupt after zero");

   chk_held_idle: assert property (@(posedge clk) disable iff (rst)
      (!running && !wr) |=> $stable(count_now)) // R4
      else $error("count moved while disabled");

   chk_ctrl_reset: assert property (@(posedge clk)
      $fell(rst) |-> (ctrl_r == cdt_pkg::CTRL_RESET)) // R13
      else $error("control not zero after reset");

   chk_reload_write: assert property (@(posedge clk) disable iff (rst)
      (wr && addr == cdt_pkg::ADDR_HIGH_RELOAD) |=>
      (high_reload_r == $past(wdata))) // R9
      else $error("reload write not taken");

   sequence seq_zero_seen;
      zero_evt && irq_mask_r[cdt_pkg::IRQ_ZERO_BIT] && !wr;
   endsequence

   sequence seq_irq_rises;
      irq_status_r[cdt_pkg::IRQ_ZERO_BIT] ##1 irq_r;
   endsequence

   sequence seq_reload_hit;
      zero_evt && auto_reload && !wr;
   endsequence

   sequence seq_enable_idle;
      !running && wr_ctrl && wdata[cdt_pkg::CTRL_ENABLE_BIT];
   endsequence

   chk_status_then_irq: assert property (@(posedge clk) disable iff (rst) // R5
      seq_zero_seen |=> seq_irq_rises)
      else $error("status or interrupt missing after zero");

   chk_status_sets: assert property (@(posedge clk) disable iff (rst) // R5
      zero_evt |=> irq_status_r[cdt_pkg::IRQ_ZERO_BIT])
      else $error("zero event did not set status");

   chk_irq_follows: assert property (@(posedge clk) disable iff (rst) // R5
      1'b1 |=> (irq_r == $past(|(irq_status_r & irq_mask_r))))
      else $error("interrupt does not follow status and mask");

   chk_masked_quiet: assert property (@(posedge clk) disable iff (rst) // R5
      (irq_mask_r == cdt_pkg::BYTE_ZERO) |=> !irq_r)
      else $error("interrupt raised while masked");

   chk_mask_bits: assert property (@(posedge clk) disable iff (rst)
      (irq_mask_r[7:1] == 7'h00))
      else $error("unused mask bits set");

   chk_reload_runs_on: assert property (@(posedge clk) disable iff (rst) // R7
      seq_reload_hit |=> running)
      else $error("auto-reload timer stopped at zero");

   chk_enable_holds: assert property (@(posedge clk) disable iff (rst) // R4
      seq_enable_idle |=> $stable(count_now))
      else $error("count loaded when enabled");

   chk_single_rest: assert property (@(posedge clk) disable iff (rst) // R6
      (zero_evt && !auto_reload && !wr) |=> (count_now == 16'h0000))
      else $error("single shot count left zero");

   chk_no_restart: assert property (@(posedge clk) disable iff (rst) // R6
      (!running && !wr_ctrl) |=> !running)
      else $error("timer enabled itself");

   chk_borrow_high: assert property (@(posedge clk) disable iff (rst) // R15
      (running && !wr && !at_zero && low_bif.value == cdt_pkg::BYTE_ZERO)
      |=> (high_bif.value == $past(high_bif.value) - 8'h01))
      else $error("high byte missed borrow");

   chk_high_hold: assert property (@(posedge clk) disable iff (rst) // R15
      (running && !wr && !at_zero && low_bif.value != cdt_pkg::BYTE_ZERO)
      |=> $stable(high_bif.value))
      else $error("high byte moved without borrow");

   chk_high_sw_wins: assert property (@(posedge clk) disable iff (rst) // R10
      wr_high_cnt |=> (high_bif.value == $past(wdata)))
      else $error("software high count write lost");

   chk_ctrl_write: assert property (@(posedge clk) disable iff (rst) // R14
      wr_ctrl |=> (ctrl_r == $past(wdata)))
      else $error("control write not taken");

   chk_low_reload_wr: assert property (@(posedge clk) disable iff (rst) // R9
      (wr && addr == cdt_pkg::ADDR_LOW_RELOAD) |=>
      (low_reload_r == $past(wdata)))
      else $error("low reload write not taken");

   chk_rdata_idle: assert property (@(posedge clk) disable iff (rst) // R3
      !rd |=> (rdata_r == cdt_pkg::BYTE_ZERO))
      else $error("read data not zero outside a read");

   chk_read_low: assert property (@(posedge clk) disable iff (rst) // R3
      (rd && addr == cdt_pkg::ADDR_LOW_COUNT) |=>
      (rdata_r == $past(low_bif.value)))
      else $error("low count read wrong");

   chk_read_high: assert property (@(posedge clk) disable iff (rst) // R2
      (rd && addr == cdt_pkg::ADDR_HIGH_COUNT) |=>
      (rdata_r == $past(high_bif.value)))
      else $error("high count read wrong");

   chk_read_ctrl: assert property (@(posedge clk) disable iff (rst) // R14
      (rd && addr == cdt_pkg::ADDR_CTRL_LOW) |=>
      (rdata_r == $past(ctrl_r)))
      else $error("control read wrong");

   chk_read_status: assert property (@(posedge clk) disable iff (rst) // R5
      (rd && addr == cdt_pkg::ADDR_IRQ_STATUS) |=>
      (rdata_r == $past(irq_status_r)))
      else $error("status read wrong");

   chk_read_unmapped: assert property (@(posedge clk) disable iff (rst)
      (rd && addr > cdt_pkg::ADDR_IRQ_MASK) |=>
      (rdata_r == cdt_pkg::BYTE_ZERO))
      else $error("unmapped read not zero");
endmodule // cdt_timer

// ===== testbench/tb_top.sv
// Purpose: self-checking bench for the cascaded down timer
// Assumes: read data stands one cycle after rd, one step per clock
// Notes:   waits are sized from one decrement per clock
`timescale 1ns/1ps
module tb_top;
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic       wr = 1'b0;
   logic       rd = 1'b0;
   logic [7:0] rdata;
   logic       irq;
   logic [7:0] rv;
   int         num_errors = 0;
   int         tests_run = 0;
   int         cycles = 0;

   always #5 clk = ~clk;

   cdt_timer dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
                  .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));

   task automatic bus(input logic w, input logic r, input logic [7:0] a,
                      input logic [7:0] d);
      wr <= w;
      rd <= r;
      addr <= a;
      wdata <= d;
      @(posedge clk);
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, 1'b0, a, d);
   endtask

   // data taken at the edge that closes the cycle in which they stand
   task automatic rd_reg(input logic [7:0] a);
      bus(1'b0, 1'b1, a, 8'h00);
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
      rv = rdata;
   endtask

   task automatic idle(input int n);
      wr <= 1'b0;
      rd <= 1'b0;
      repeat (n) @(posedge clk);
   endtask

   task automatic chk(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp,
                         input string what);
      rd_reg(a);
      chk(what, exp, rv);
   endtask

   // exact step count depends on write-to-enable latency, so a window
   task automatic rd_in(input logic [7:0] a, input logic [7:0] lo,
                        input logic [7:0] hi, input string what);
      rd_reg(a);
      chk(what, 8'h01, {7'h00, (rv >= lo && rv <= hi)});
   endtask

   task automatic give_verdict;
      $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         num_errors++;
         give_verdict();
      end
   end

   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd_chk(cdt_pkg::ADDR_CTRL_LOW, 8'h00, "control");
      rd_chk(cdt_pkg::ADDR_IRQ_MASK, 8'h00, "mask");
      $display("test reset done");
      wr_reg(cdt_pkg::ADDR_LOW_RELOAD, 8'ha5);
      wr_reg(cdt_pkg::ADDR_HIGH_RELOAD, 8'h5a);
      wr_reg(cdt_pkg::ADDR_LOW_COUNT, 8'h02);
      wr_reg(cdt_pkg::ADDR_HIGH_COUNT, 8'h01);
      wr_reg(8'hd0, 8'hff);
      rd_chk(cdt_pkg::ADDR_LOW_RELOAD, 8'ha5, "low reload");
      rd_chk(cdt_pkg::ADDR_HIGH_RELOAD, 8'h5a, "high reload");
      rd_chk(cdt_pkg::ADDR_LOW_COUNT, 8'h02, "low count");
      rd_chk(cdt_pkg::ADDR_HIGH_COUNT, 8'h01, "high count");
      rd_chk(8'hd0, 8'h00, "unmapped");
      $display("test access done");
      wr_reg(cdt_pkg::ADDR_IRQ_MASK, 8'h01);
      wr_reg(cdt_pkg::ADDR_CTRL_LOW, 8'h01);
      idle(4);
      rd_in(cdt_pkg::ADDR_LOW_COUNT, 8'hf9, 8'hfe, "low count");
      rd_chk(cdt_pkg::ADDR_HIGH_COUNT, 8'h00, "high count");
      idle(260);
      rd_chk(cdt_pkg::ADDR_CTRL_LOW, 8'h00, "control");
      rd_chk(cdt_pkg::ADDR_LOW_COUNT, 8'h00, "low count");
      rd_chk(cdt_pkg::ADDR_HIGH_COUNT, 8'h00, "high count");
      rd_chk(cdt_pkg::ADDR_IRQ_STATUS, 8'h01, "status");
      chk("irq", 8'h01, {7'h00, irq});
      wr_reg(cdt_pkg::ADDR_IRQ_STATUS, 8'h01);
      idle(3);
      chk("irq", 8'h00, {7'h00, irq});
      $display("test single shot done");
      wr_reg(cdt_pkg::ADDR_LOW_COUNT, 8'h30);
      wr_reg(cdt_pkg::ADDR_HIGH_COUNT, 8'h00);
      wr_reg(cdt_pkg::ADDR_HIGH_RELOAD, 8'h00);
      wr_reg(cdt_pkg::ADDR_LOW_RELOAD, 8'h20);
      wr_reg(cdt_pkg::ADDR_CTRL_LOW, 8'h03);
      wr_reg(cdt_pkg::ADDR_LOW_RELOAD, 8'h40);
      wr_reg(cdt_pkg::ADDR_LOW_COUNT, 8'h05);
      idle(10);
      rd_in(cdt_pkg::ADDR_LOW_COUNT, 8'h36, 8'h3f, "low count");
      rd_chk(cdt_pkg::ADDR_CTRL_LOW, 8'h03, "control");
      wr_reg(cdt_pkg::ADDR_LOW_COUNT, 8'h80);
      rd_chk(cdt_pkg::ADDR_LOW_COUNT, 8'h80, "low count");
      $display("test reload done");
      wr_reg(cdt_pkg::ADDR_CTRL_LOW, 8'h00);
      wr_reg(cdt_pkg::ADDR_IRQ_MASK, 8'h00);
      idle(3);
      rd_chk(cdt_pkg::ADDR_IRQ_STATUS, 8'h01, "status");
      chk("irq", 8'h00, {7'h00, irq});
      wr_reg(cdt_pkg::ADDR_IRQ_STATUS, 8'h01);
      rd_chk(cdt_pkg::ADDR_IRQ_STATUS, 8'h00, "status");
      $display("test mask done");
      give_verdict();
   end
endmodule // tb_top
